// ### hw/bjm_cfg.svh
// Opcode encodings, instruction lengths and reset values for the branch/jump/move executor
`ifndef BJM_CFG_SVH
`define BJM_CFG_SVH
`define OP_BRANCH_IF_CARRY 8'h40
`define OP_BRANCH_IF_NO_CARRY 8'h50
`define OP_BRANCH_IF_BIT_CLEAR 8'h30
`define OP_BRANCH_IF_ACC_NONZERO 8'h70
`define OP_BRANCH_IF_ACC_ZERO 8'h60
`define OP_INDIRECT_TABLE_JUMP 8'h73
`define OP_LONG_SUBROUTINE_CALL 8'h12
`define OP_LONG_ABSOLUTE_JUMP 8'h02
`define OP_COPY_REG_TO_ACC_MASK 8'hF8
`define OP_COPY_REG_TO_ACC 8'hE8
`define LEN_TWO 16'h0002
`define LEN_THREE 16'h0003
`define LEN_ONE 16'h0001
`define RST_PC 16'h0000
`define RST_ACC 8'h00
`define RST_SP 8'h07
`define RST_DATA_POINTER 16'h0000
`define RST_CARRY 1'b0
`define RST_BANK 2'h0
`endif

// ### hw/bjm_pkg.sv
// Types shared by the branch/jump/move executor
package bjm_pkg;
   typedef enum logic [5:0] {
      ST_FETCH = 6'h01,
      ST_OPER1 = 6'h02,
      ST_OPER2 = 6'h04,
      ST_EXEC = 6'h08,
      ST_PUSH_HI = 6'h10,
      ST_HALT = 6'h20
   } exec_state_t;
   typedef logic [15:0] addr_t;
   typedef logic [7:0] byte_t;
endpackage : bjm_pkg

// ### hw/bjm_iram.sv
// Internal data memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module bjm_iram #(
   parameter int DEPTH = 256
) (
   input wire logic clk_sys_i,
   input wire logic we_i,
   input wire logic [7:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] raddr_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [DEPTH];
   always_ff @(posedge clk_sys_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule : bjm_iram
`default_nettype wire

// ### hw/bjm_target.sv
// Branch target arithmetic: next address plus optional sign-extended displacement
`timescale 1ns/10ps
`default_nettype none
module bjm_target (
   input wire logic [15:0] pc_i,
   input wire logic [15:0] len_i,
   input wire logic [7:0] rel_i,
   input wire logic take_i,
   output logic [15:0] target_o
);
   logic [15:0] next_pc;
   always_comb begin
      next_pc = pc_i + len_i;
      target_o = take_i ? next_pc + {{8{rel_i[7]}}, rel_i} : next_pc;
   end
endmodule : bjm_target
`default_nettype wire

// ### hw/branch_jump_move_exec.sv
// Executor for relative branches, table jump, long call/jump and register-to-accumulator copy
// Function
// RULE_01 - carry branch: two bytes, taken on carry
// RULE_02 - relative: advance two, add signed displacement
// RULE_03 - table jump: accumulator plus data pointer
// RULE_04 - table jump changes only program counter
// RULE_05 - bit-clear branch: taken on zero bit
// RULE_06 - bit branch: advance three, add displacement
// RULE_07 - no-carry branch: taken on clear carry
// RULE_08 - nonzero branch: any accumulator bit set
// RULE_09 - zero branch: all accumulator bits clear
// RULE_10 - accumulator branches keep accumulator and flags
// RULE_11 - long call pushes pc plus three
// RULE_12 - stack pointer pre-incremented twice
// RULE_13 - long call loads target, no flags
// RULE_14 - long jump loads 16-bit target
// RULE_15 - copy leaves source and others unchanged
// RULE_16 - register copy into accumulator, one byte
// RULE_17 - working register from active bank
`include "bjm_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module branch_jump_move_exec #(
   parameter int IRAM_DEPTH = 256
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Program memory: address out, byte back in the same cycle
   output bjm_pkg::addr_t code_addr_o,
   input wire bjm_pkg::byte_t code_data_i,
   // Directly addressed bit value, supplied by the bit space outside
   output bjm_pkg::byte_t bit_addr_o,
   input wire logic bit_value_i,
   // Architectural state loaded from outside (other instructions)
   input wire logic load_i,
   input wire bjm_pkg::byte_t load_acc_i,
   input wire logic [15:0] load_data_pointer_i,
   input wire logic load_carry_i,
   input wire logic [1:0] load_bank_i,
   input wire bjm_pkg::byte_t load_sp_i,
   // Observed state
   output bjm_pkg::addr_t pc_o,
   output bjm_pkg::byte_t acc_o,
   output logic [15:0] data_pointer_o,
   output logic carry_o,
   output bjm_pkg::byte_t sp_o,
   output logic [1:0] bank_o,
   output logic retire_o,
   output logic illegal_o
);
   import bjm_pkg::*;

   // ==========================================================
   // Decode helpers
   function automatic logic is_reg_copy(input byte_t op);
      return (op & `OP_COPY_REG_TO_ACC_MASK) == `OP_COPY_REG_TO_ACC;
   endfunction : is_reg_copy

   function automatic logic [15:0] op_len(input byte_t op);
      logic [15:0] len;
      len = `LEN_ONE;
      if (op == `OP_BRANCH_IF_BIT_CLEAR || op == `OP_LONG_SUBROUTINE_CALL
          || op == `OP_LONG_ABSOLUTE_JUMP) begin
         len = `LEN_THREE;
      end else if (op == `OP_BRANCH_IF_CARRY || op == `OP_BRANCH_IF_NO_CARRY
                   || op == `OP_BRANCH_IF_ACC_ZERO || op == `OP_BRANCH_IF_ACC_NONZERO) begin
         len = `LEN_TWO;
      end
      return len;
   endfunction : op_len

   function automatic logic is_known(input byte_t op);
      return is_reg_copy(op) || op_len(op) != `LEN_ONE || op == `OP_INDIRECT_TABLE_JUMP;
   endfunction : is_known

   // Program counter after the step that ends an instruction; shared by the program
   // counter and the fetch address so the next opcode is read without a lost cycle
   function automatic addr_t retire_target(input exec_state_t st, input byte_t op,
      input addr_t pc, input addr_t rel_pc, input addr_t table_pc, input addr_t abs_pc);
      addr_t nxt;
      nxt = pc;
      if (st == ST_PUSH_HI) begin
         nxt = abs_pc; // [RULE_13]
      end else if (st == ST_EXEC) begin
         case (op)
            `OP_INDIRECT_TABLE_JUMP: nxt = table_pc; // [RULE_03]
            `OP_LONG_ABSOLUTE_JUMP: nxt = abs_pc; // [RULE_14]
            // A call keeps its own address until the high return byte is pushed
            `OP_LONG_SUBROUTINE_CALL: nxt = pc;
            default: nxt = is_reg_copy(op) ? pc + `LEN_ONE : rel_pc; // [RULE_16] [RULE_02]
         endcase
      end
      return nxt;
   endfunction : retire_target

   // ==========================================================
   // State
   exec_state_t state_q;
   addr_t pc_q;
   addr_t fetch_q;
   byte_t opcode_q;
   byte_t oper1_q;
   byte_t oper2_q;
   byte_t acc_q;
   logic [15:0] data_pointer_q;
   logic carry_q;
   byte_t sp_q;
   logic [1:0] bank_q;
   logic retire_q;
   logic illegal_q;

   logic take;
   addr_t rel_target;
   logic iram_we;
   byte_t iram_waddr;
   byte_t iram_wdata;
   byte_t iram_raddr;
   byte_t iram_rdata;
   addr_t ret_addr;
   addr_t table_pc;
   addr_t abs_pc;
   addr_t pc_next;

   // ==========================================================
   // Branch condition
   always_comb begin
      take = 1'b0;
      case (opcode_q)
         `OP_BRANCH_IF_CARRY: take = carry_q; // [RULE_01]
         `OP_BRANCH_IF_NO_CARRY: take = ~carry_q; // [RULE_07]
         `OP_BRANCH_IF_ACC_NONZERO: take = |acc_q; // [RULE_08]
         `OP_BRANCH_IF_ACC_ZERO: take = ~(|acc_q); // [RULE_09]
         `OP_BRANCH_IF_BIT_CLEAR: take = ~bit_value_i; // [RULE_05]
         default: take = 1'b0;
      endcase
   end

   // Displacement is the last operand byte: second for two-byte, third for three-byte
   bjm_target u_target (
      .pc_i(pc_q),
      .len_i(op_len(opcode_q)), // [RULE_02] [RULE_06]
      .rel_i(opcode_q == `OP_BRANCH_IF_BIT_CLEAR ? oper2_q : oper1_q), // [RULE_06]
      .take_i(take),
      .target_o(rel_target)
   );

   assign ret_addr = pc_q + `LEN_THREE; // [RULE_11]

   // ==========================================================
   // Program counter targets
   // Table sum is sixteen bits wide so a low-byte carry reaches the high byte
   assign table_pc = {8'h00, acc_q} + data_pointer_q; // [RULE_03]
   assign abs_pc = {oper1_q, oper2_q}; // [RULE_13] [RULE_14]
   assign pc_next = retire_target(state_q, opcode_q, pc_q, rel_target, table_pc, abs_pc);

   // ==========================================================
   // Internal memory ports: stack push and working register read
   always_comb begin
      iram_we = 1'b0;
      iram_waddr = sp_q + 8'h01; // [RULE_12]
      iram_wdata = ret_addr[7:0]; // [RULE_11]
      if (state_q == ST_EXEC && opcode_q == `OP_LONG_SUBROUTINE_CALL) begin
         iram_we = 1'b1;
      end else if (state_q == ST_PUSH_HI) begin
         iram_we = 1'b1;
         iram_wdata = ret_addr[15:8]; // [RULE_11]
      end
      // Read issued during fetch so the register byte is ready at execute
      iram_raddr = {3'h0, bank_q, code_data_i[2:0]}; // [RULE_17]
   end

   bjm_iram #(
      .DEPTH(IRAM_DEPTH)
   ) u_iram (
      .clk_sys_i(clk_sys_i),
      .we_i(iram_we),
      .waddr_i(iram_waddr),
      .wdata_i(iram_wdata),
      .raddr_i(iram_raddr),
      .rdata_o(iram_rdata)
   );

   // ==========================================================
   // Sequencer
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= ST_FETCH;
      end else begin
         case (state_q)
            ST_FETCH: begin
               if (!load_i) begin
                  if (!is_known(code_data_i)) begin
                     state_q <= ST_HALT;
                  end else if (is_reg_copy(code_data_i)
                               || code_data_i == `OP_INDIRECT_TABLE_JUMP) begin
                     state_q <= ST_EXEC;
                  end else begin
                     state_q <= ST_OPER1;
                  end
               end
            end
            ST_OPER1: state_q <= (op_len(opcode_q) == `LEN_THREE) ? ST_OPER2 : ST_EXEC;
            ST_OPER2: state_q <= ST_EXEC;
            ST_EXEC: begin
               state_q <= (opcode_q == `OP_LONG_SUBROUTINE_CALL) ? ST_PUSH_HI : ST_FETCH;
            end
            ST_PUSH_HI: state_q <= ST_FETCH;
            ST_HALT: state_q <= load_i ? ST_FETCH : ST_HALT;
            default: state_q <= ST_FETCH;
         endcase
      end
   end

   // Fetch address walks the operand bytes, holds while state is loaded, and then follows
   // the retiring program counter so the next opcode comes from the new location at once
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fetch_q <= `RST_PC;
      end else if ((state_q == ST_FETCH && !load_i) || state_q == ST_OPER1) begin
         fetch_q <= fetch_q + `LEN_ONE;
      end else if (state_q == ST_FETCH || state_q == ST_OPER2) begin
         fetch_q <= fetch_q;
      end else begin
         fetch_q <= pc_next; // [RULE_02] [RULE_14]
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         opcode_q <= 8'h00;
      end else if (state_q == ST_FETCH) begin
         opcode_q <= code_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         oper1_q <= 8'h00;
      end else if (state_q == ST_OPER1) begin
         oper1_q <= code_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         oper2_q <= 8'h00;
      end else if (state_q == ST_OPER2) begin
         oper2_q <= code_data_i;
      end
   end

   // Program counter moves only when an instruction ends
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pc_q <= `RST_PC;
      end else if (state_q == ST_EXEC || state_q == ST_PUSH_HI) begin
         pc_q <= pc_next; // [RULE_03] [RULE_13] [RULE_14]
      end
   end

   // Accumulator changes only on a load or the register copy; branches leave it alone
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_q <= `RST_ACC;
      end else if (state_q == ST_FETCH && load_i) begin
         acc_q <= load_acc_i;
      end else if (state_q == ST_EXEC && is_reg_copy(opcode_q)) begin
         acc_q <= iram_rdata; // [RULE_16] [RULE_15] [RULE_10]
      end
   end

   // Data pointer, carry and bank are never written by this group; only a load moves them
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         data_pointer_q <= `RST_DATA_POINTER;
      end else if ((state_q == ST_FETCH || state_q == ST_HALT) && load_i) begin
         data_pointer_q <= load_data_pointer_i; // [RULE_04]
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         carry_q <= `RST_CARRY;
      end else if ((state_q == ST_FETCH || state_q == ST_HALT) && load_i) begin
         carry_q <= load_carry_i; // [RULE_07] [RULE_10]
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bank_q <= `RST_BANK;
      end else if ((state_q == ST_FETCH || state_q == ST_HALT) && load_i) begin
         bank_q <= load_bank_i; // [RULE_17]
      end
   end

   // Stack pointer steps before each push byte, so both bytes land above the old top
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sp_q <= `RST_SP;
      end else if ((state_q == ST_FETCH || state_q == ST_HALT) && load_i) begin
         sp_q <= load_sp_i;
      end else if (iram_we) begin
         sp_q <= sp_q + 8'h01; // [RULE_12]
      end
   end

   // Retire marks the first cycle in which the new program counter is visible
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         retire_q <= 1'b0;
      end else begin
         retire_q <= (state_q == ST_EXEC && opcode_q != `OP_LONG_SUBROUTINE_CALL)
                     || state_q == ST_PUSH_HI;
      end
   end

   // Illegal stays up while halted, so a stray fetch is seen until state is reloaded
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         illegal_q <= 1'b0;
      end else begin
         illegal_q <= (state_q == ST_FETCH && !load_i && !is_known(code_data_i))
                      || (state_q == ST_HALT && !load_i);
      end
   end

   // ==========================================================
   // Outputs
   assign code_addr_o = fetch_q;
   assign bit_addr_o = oper1_q; // [RULE_05]
   assign pc_o = pc_q;
   assign acc_o = acc_q;
   assign data_pointer_o = data_pointer_q;
   assign carry_o = carry_q;
   assign sp_o = sp_q;
   assign bank_o = bank_q;
   assign retire_o = retire_q;
   assign illegal_o = illegal_q;
endmodule : branch_jump_move_exec
`default_nettype wire

// ### test/bjm_code_rom.sv
// Program memory model answering each address in the same cycle
`timescale 1ns/10ps
`default_nettype none
module bjm_code_rom
   import bjm_pkg::*;
(
   input wire bjm_pkg::addr_t addr_i,
   output bjm_pkg::byte_t data_o
);
   byte_t mem [0:65535];
   // Unused bytes hold an undefined opcode, so a stray fetch halts
   initial begin
      foreach (mem[i]) mem[i] = 8'hA5;
   end
   assign data_o = mem[addr_i];
endmodule : bjm_code_rom
`default_nettype wire

// ### test/bjm_exec_sva.sv
// Checker for the branch, jump, call and copy executor
`timescale 1ns/10ps
`default_nettype none
module bjm_exec_sva
   import bjm_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire bjm_pkg::addr_t code_addr_o,
   input wire bjm_pkg::byte_t code_data_i,
   input wire logic bit_value_i,
   input wire logic load_i,
   input wire bjm_pkg::addr_t pc_o,
   input wire bjm_pkg::byte_t acc_o,
   input wire logic [15:0] data_pointer_o,
   input wire logic carry_o,
   input wire bjm_pkg::byte_t sp_o,
   input wire logic retire_o,
   input wire logic illegal_o
);
   logic busy_q;
   byte_t op_q, b2_q, b3_q;
   addr_t p_q;
   wire logic opc_edge = (retire_o || !busy_q) && !load_i;
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_q <= 1'b0;
      end else if (retire_o || !busy_q || (illegal_o && load_i)) begin
         busy_q <= !load_i;
      end
   end
   // Operand capture by address; a stale byte only ever lands before it is used
   always_ff @(posedge clk_sys_i) begin
      if (opc_edge) begin
         op_q <= code_data_i;
         p_q <= pc_o;
      end
      if (code_addr_o == p_q + 16'h0001) b2_q <= code_data_i;
      if (code_addr_o == p_q + 16'h0002) b3_q <= code_data_i;
   end
   function automatic addr_t hop(input addr_t base, input byte_t d);
      return base + {{8{d[7]}}, d};
   endfunction : hop
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   sequence call_taken;
      opc_edge && code_data_i == 8'h12;
   endsequence
   sequence table_taken;
      opc_edge && code_data_i == 8'h73;
   endsequence
   a_carry_branch: assert property (retire_o && op_q == 8'h40 |-> pc_o ==
      (carry_o ? hop(p_q + 16'h0002, b2_q) : p_q + 16'h0002)) else $error("carry branch");
   a_nocarry_branch: assert property (retire_o && op_q == 8'h50 |-> pc_o ==
      (!carry_o ? hop(p_q + 16'h0002, b2_q) : p_q + 16'h0002)) else $error("no-carry branch");
   a_bit_branch: assert property (retire_o && op_q == 8'h30 |-> pc_o ==
      (!bit_value_i ? hop(p_q + 16'h0003, b3_q) : p_q + 16'h0003)) else $error("bit branch");
   a_nonzero_branch: assert property (retire_o && op_q == 8'h70 |-> pc_o ==
      (acc_o != 8'h00 ? hop(p_q + 16'h0002, b2_q) : p_q + 16'h0002)) else $error("nonzero");
   a_zero_branch: assert property (retire_o && op_q == 8'h60 |-> pc_o ==
      (acc_o == 8'h00 ? hop(p_q + 16'h0002, b2_q) : p_q + 16'h0002)) else $error("zero");
   a_acc_branch_keep: assert property (opc_edge && code_data_i inside {8'h60, 8'h70} |->
      ##3 retire_o && acc_o == $past(acc_o, 3) && carry_o == $past(carry_o, 3)) else $error("keep");
   a_table_jump: assert property (table_taken |-> ##2 retire_o && acc_o == $past(acc_o, 2) &&
      pc_o == {8'h00, acc_o} + data_pointer_o && data_pointer_o == $past(data_pointer_o, 2)) else $error("table jump");
   a_call_stack: assert property (call_taken |-> ##5 retire_o && sp_o == $past(sp_o, 5) + 8'h02 &&
      pc_o == {b2_q, b3_q} && carry_o == $past(carry_o, 5)) else $error("call");
   a_long_jump: assert property (retire_o && op_q == 8'h02 |-> pc_o == {b2_q, b3_q})
      else $error("long jump");
   a_copy_step: assert property (opc_edge && (code_data_i & 8'hF8) == 8'hE8 |-> ##2 retire_o &&
      pc_o == $past(pc_o, 2) + 16'h0001 && sp_o == $past(sp_o, 2)) else $error("copy");
endmodule : bjm_exec_sva
bind branch_jump_move_exec bjm_exec_sva i_bjm_exec_sva (.clk_sys_i, .nrst_i, .code_addr_o,
   .code_data_i, .bit_value_i, .load_i, .pc_o, .acc_o, .data_pointer_o, .carry_o, .sp_o, .retire_o,
   .illegal_o);
`default_nettype wire

// ### test/testbench.sv
// Bench running one program through the executor with fresh random state each run
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import bjm_pkg::*;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic load_i = 1'b0;
   logic bit_value_i = 1'b0;
   logic load_carry_i = 1'b0;
   logic [1:0] load_bank_i = 2'h0;
   byte_t load_acc_i = 8'h00;
   byte_t load_sp_i = 8'h00;
   addr_t load_data_pointer_i = 16'h0000;
   addr_t code_addr_o, pc_o, data_pointer_o;
   byte_t code_data_i, acc_o, sp_o;
   logic carry_o, retire_o, illegal_o, c_r;
   addr_t d_r;
   logic b_r = 1'b0;
   logic [1:0] k_r = 2'h0;
   byte_t bit_addr_o;
   logic [1:0] bank_o;
   logic [50:0] exp_q[$];
   logic [31:0] rnd = 32'h1C735496;
   int failures = 0;
   int n_compared = 0;
   branch_jump_move_exec i_branch_jump_move_exec (.clk_sys_i, .nrst_i, .code_addr_o, .code_data_i,
      .bit_addr_o, .bit_value_i, .load_i, .load_acc_i, .load_data_pointer_i, .load_carry_i,
      .load_bank_i, .load_sp_i, .pc_o, .acc_o, .data_pointer_o, .carry_o, .sp_o, .bank_o, .retire_o,
      .illegal_o);
   // Bit space: only the tested address holds the chosen value, so a wrong address flips it
   always @(posedge clk_sys_i) bit_value_i <= (bit_addr_o == 8'h55) ? b_r : ~b_r;
   bjm_code_rom i_bjm_code_rom (.addr_i(code_addr_o), .data_o(code_data_i));
   always #12.5 clk_sys_i = ~clk_sys_i;
   // ==========================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return v[0] ? (v >> 1) ^ 32'hA3000000 : v >> 1;
   endfunction : lfsr
   task automatic put(input addr_t a, input logic [23:0] v);
      i_bjm_code_rom.mem[a] = v[23:16];
      i_bjm_code_rom.mem[a + 16'h0001] = v[15:8];
      i_bjm_code_rom.mem[a + 16'h0002] = v[7:0];
   endtask : put
   task automatic note(input addr_t p, input byte_t a, input byte_t s);
      exp_q.push_back({p, a, s, c_r, k_r, d_r});
   endtask : note
   task automatic check(input logic [50:0] got);
      logic [50:0] e;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      n_compared++;
      if (got !== e) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask : check
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   // State is compared at every retire against the oldest note
   always @(posedge clk_sys_i) begin
      if (retire_o === 1'b1) check({pc_o, acc_o, sp_o, carry_o, bank_o, data_pointer_o});
   end
   // ==========================================
   // One run: reset, load random state, follow the program until it halts
   task automatic run(input int n);
      byte_t a;
      byte_t s;
      repeat (24) rnd = lfsr(rnd);
      a = rnd[7:0] | 8'h01;
      d_r = {8'h40, rnd[15:8]};
      c_r = rnd[16];
      b_r = rnd[17];
      k_r = rnd[19:18];
      // Stack placed so the two pushed bytes become r0 and r1 of the bank
      s = {3'h0, k_r, 3'h0} - 8'h01;
      put(d_r + {8'h00, a}, 24'h02002D);
      @(posedge clk_sys_i);
      nrst_i <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      load_i <= 1'b1;
      load_acc_i <= a;
      load_data_pointer_i <= d_r;
      load_carry_i <= c_r;
      load_bank_i <= k_r;
      load_sp_i <= s;
      if (!c_r) note(16'h0002, a, s);
      note(16'h0008, a, s);
      if (!c_r) note(16'h001A, a, s);
      note(16'h000A, a, s);
      note(16'h002C, a, s);
      note(d_r + {8'h00, a}, a, s);
      note(16'h002D, a, s);
      note(16'h002F, a, s);
      note(b_r ? 16'h0032 : 16'h0022, a, s);
      note(16'h0040, a, s);
      note(16'h0100, a, s + 8'h02);
      note(16'h0101, 8'h43, s + 8'h02);
      note(16'h0102, 8'h00, s + 8'h02);
      note(16'h0106, 8'h00, s + 8'h02);
      note(16'h0108, 8'h00, s + 8'h02);
      @(posedge clk_sys_i);
      load_i <= 1'b0;
      for (int i = 0; i < 400 && illegal_o !== 1'b1; i++) @(posedge clk_sys_i);
      exp_q.push_back(51'h1);
      check({50'h0, illegal_o});
      $display("run %0d done", n);
   endtask : run
   initial begin
      // Let the program memory fill its blank bytes first, or it may wipe this program
      #1;
      put(16'h0000, 24'h400650);
      put(16'h0003, 24'h04A5A5);
      put(16'h0008, 24'h501070);
      put(16'h000B, 24'h20A5A5);
      put(16'h001A, 24'h02000A);
      put(16'h002C, 24'h736010);
      put(16'h002F, 24'h3055F0);
      put(16'h0022, 24'h020040);
      put(16'h0032, 24'h020040);
      put(16'h0040, 24'h120100);
      put(16'h0100, 24'hE8E960);
      put(16'h0103, 24'h02A5A5);
      put(16'h0106, 24'h7005A5);
      for (int n = 0; n < 4; n++) run(n);
      summarize();
   end
   // A run takes about 60 cycles; 2000 cycles leaves ample margin
   initial begin
      #50000;
      failures++;
      summarize();
   end
endmodule : testbench
`default_nettype wire
